// *** hw/wiper_stepper.sv ***
`timescale 1ns/1ns
`include "wiper_map.svh"
// Behaviour
// - Wiper holds one of 64 tap positions.
// - Control inputs are active low, idle high.
// - A falling edge starts a pulse or contact closure.
// - Each valid pulse moves the wiper exactly one tap.
// - Contact low periods split by under 1 ms high merge into one pulse; step input merges only highs under 1 us.
// - Held beyond 1 s, wiper steps again every 100 ms.
// - Single button mode uses up contact only, ignores down contact.
// - Single button mode needs down contact tied to supply at power-up.
// - Floating down contact at power-up selects dual button mode.
// - Single button motion starts opposite to the previous direction.
// - Single button direction reverses after 1 s idle or at range end.
// - Step input always works, single-button style, with faster stepping.
// - Dual mode: up contact steps up, down contact steps down.
// - Dual mode changes direction at once on opposite input.
// - Dual mode holds at range end until opposite input.
// - Contact inputs are debounced internally.
// - Power-up restores wiper from nonvolatile storage.
// - Changes are stored after 2 s; first change always stored.
// - Later stores happen only when position bit 3 changes.
module wiper_stepper #(
  parameter int TICK_CYCLES = `WIPER_TICK_CYCLES,
  parameter int CONTACT_MIN_CYCLES = `WIPER_CONTACT_MIN_CYCLES,
  parameter int STEP_MIN_CYCLES = `WIPER_STEP_MIN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic up_contact_in_n,
  input wire logic down_contact_in_n,
  input wire logic step_in_n,
  input wire logic down_tied_supply,
  input wire logic [5:0] nv_restore_pos,
  output logic [5:0] wiper_pos,
  output logic nv_write,
  output logic [5:0] nv_write_pos,
  output logic single_mode,
  output logic ready
);
  // ------------------------------------------------------------
  // Input conditioning and timebase
  // ------------------------------------------------------------
  contact_if up_c ();
  contact_if down_c ();
  contact_if step_c ();
  logic tick;

  contact_filter #(.MIN_CYCLES(CONTACT_MIN_CYCLES)) u_up (
    .core_clk(core_clk), .rst_n(rst_n), .pin_n(up_contact_in_n), .out(up_c)
  );
  contact_filter #(.MIN_CYCLES(CONTACT_MIN_CYCLES)) u_down (
    .core_clk(core_clk), .rst_n(rst_n), .pin_n(down_contact_in_n), .out(down_c)
  );
  // Step input needs no bounce rejection, so its window is far shorter
  contact_filter #(.MIN_CYCLES(STEP_MIN_CYCLES)) u_step (
    .core_clk(core_clk), .rst_n(rst_n), .pin_n(step_in_n), .out(step_c)
  );
  ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .core_clk(core_clk), .rst_n(rst_n), .tick(tick)
  );

  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  logic strap1;
  logic strap2;
  logic strap3;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap1 <= 1'b0;
      strap2 <= 1'b0;
      strap3 <= 1'b0;
    end else begin
      strap1 <= down_tied_supply;
      strap2 <= strap1;
      strap3 <= strap2;
    end
  end

  // Capture waits one tick so the sync chain has long settled
  wire start_now = !ready && tick && (strap2 == strap3);

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  logic dir_up;
  logic rev_pending;
  logic first_done;
  logic store_armed;
  logic [5:0] stored_pos;
  wiper_pkg::ms_t hold_ms;
  wiper_pkg::ms_t idle_ms;
  wiper_pkg::ms_t store_ms;
  wiper_pkg::source_e src;
  wiper_pkg::source_e next_src;

  wire down_live = down_c.asserted && !single_mode;
  assign next_src = step_c.asserted ? wiper_pkg::SRC_STEP :
                    up_c.asserted ? wiper_pkg::SRC_UP :
                    down_live ? wiper_pkg::SRC_DOWN : wiper_pkg::SRC_NONE;
  wire src_press = (next_src == wiper_pkg::SRC_STEP) ? step_c.press :
                   (next_src == wiper_pkg::SRC_UP) ? up_c.press :
                   (next_src == wiper_pkg::SRC_DOWN) ? down_c.press : 1'b0;
  wire held = (next_src != wiper_pkg::SRC_NONE) && (next_src == src);
  wire repeat_evt = held && !src_press && tick &&
                    (hold_ms == 11'(`WIPER_HOLD_MS - 1));
  wire move_evt = ready && (src_press || repeat_evt);

  // ------------------------------------------------------------
  // Direction decision
  // ------------------------------------------------------------
  wire single_style = single_mode || (next_src == wiper_pkg::SRC_STEP);
  wire at_top = (wiper_pos == `WIPER_POS_MAX);
  wire at_bottom = (wiper_pos == `WIPER_POS_MIN);
  // Reversal after idle applies to the first move only
  wire want_up_single = (src_press && rev_pending) ? !dir_up : dir_up;
  wire eff_up_single = at_top ? 1'b0 : (at_bottom ? 1'b1 : want_up_single);
  wire eff_up_dual = (next_src == wiper_pkg::SRC_UP);
  wire move_up = single_style ? eff_up_single : eff_up_dual;
  wire blocked = !single_style && (move_up ? at_top : at_bottom);
  wire [5:0] pos_inc = wiper_pos + 6'h01;
  wire [5:0] pos_dec = wiper_pos - 6'h01;
  wire [5:0] next_pos = move_up ? pos_inc : pos_dec;
  wire do_move = move_evt && !blocked;
  wire hits_end = move_up ? (next_pos == `WIPER_POS_MAX) : (next_pos == `WIPER_POS_MIN);
  wire next_dir_up = (single_style && hits_end) ? !move_up : move_up;

  // ------------------------------------------------------------
  // Wiper and direction
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
      single_mode <= 1'b0;
      wiper_pos <= `WIPER_POS_MIN;
      dir_up <= 1'b0;
    end else if (start_now) begin
      ready <= 1'b1;
      single_mode <= strap3;
      wiper_pos <= nv_restore_pos;
    end else if (do_move) begin
      wiper_pos <= next_pos;
      dir_up <= next_dir_up;
    end
  end

  // ------------------------------------------------------------
  // Hold, repeat and idle timing
  // ------------------------------------------------------------
  // Expiry only counts while idle, so a press on a tick still consumes the reversal
  wire idle_hit = tick && (idle_ms == 11'(`WIPER_IDLE_MS - 1)) &&
                  (next_src == wiper_pkg::SRC_NONE);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      src <= wiper_pkg::SRC_NONE;
      hold_ms <= '0;
      idle_ms <= '0;
      rev_pending <= 1'b1;
    end else begin
      src <= next_src;
      if (!held || src_press) begin
        hold_ms <= '0;
      end else if (repeat_evt) begin
        hold_ms <= 11'(`WIPER_HOLD_MS - `WIPER_REPEAT_MS);
      end else if (tick) begin
        hold_ms <= hold_ms + 11'h001;
      end
      if (next_src != wiper_pkg::SRC_NONE) begin
        idle_ms <= '0;
      end else if (tick && !idle_hit) begin
        idle_ms <= idle_ms + 11'h001;
      end
      // Idle expiry wins over a press consuming the flag
      if (idle_hit) begin
        rev_pending <= 1'b1;
      end else if (do_move && single_style) begin
        rev_pending <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Nonvolatile storage
  // ------------------------------------------------------------
  // Writes are rationed on bit 3 to spare storage endurance
  wire store_due = store_armed && tick && (store_ms == 11'(`WIPER_STORE_MS - 1));
  wire store_go = store_due &&
                  (!first_done || (wiper_pos[`WIPER_STORE_BIT] != stored_pos[`WIPER_STORE_BIT]));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_armed <= 1'b0;
      store_ms <= '0;
      first_done <= 1'b0;
      stored_pos <= `WIPER_POS_MIN;
      nv_write <= 1'b0;
      nv_write_pos <= `WIPER_POS_MIN;
    end else begin
      if (start_now) begin
        stored_pos <= nv_restore_pos;
      end else if (store_go) begin
        stored_pos <= wiper_pos;
      end
      if (do_move) begin
        store_armed <= 1'b1;
        store_ms <= '0;
      end else if (store_due) begin
        store_armed <= 1'b0;
      end else if (store_armed && tick) begin
        store_ms <= store_ms + 11'h001;
      end
      if (store_go) begin
        first_done <= 1'b1;
      end
      nv_write <= store_go;
      if (store_go) begin
        nv_write_pos <= wiper_pos;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_one_tap: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && $changed(wiper_pos) && $past(ready) |->
      (wiper_pos == $past(wiper_pos) + 6'h01) || (wiper_pos == $past(wiper_pos) - 6'h01))
    else $error("wiper moved more than one tap");
  a_press_moves: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && src_press && single_style |=> $changed(wiper_pos))
    else $error("press in single style did not move wiper");
  a_down_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && single_mode && down_c.asserted && !up_c.asserted && !step_c.asserted
      |=> $stable(wiper_pos))
    else $error("down contact moved wiper in single mode");
  a_dual_up: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && !single_mode && src_press && next_src == wiper_pkg::SRC_UP && !at_top
      |=> wiper_pos == $past(wiper_pos) + 6'h01)
    else $error("up contact did not step up");
  a_dual_down: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && !single_mode && src_press && next_src == wiper_pkg::SRC_DOWN && !at_bottom
      |=> wiper_pos == $past(wiper_pos) - 6'h01)
    else $error("down contact did not step down");
  a_dual_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && !single_mode && at_top && !down_c.asserted && !step_c.asserted
      |=> at_top)
    else $error("wiper left top end without down input");
  a_repeat_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    repeat_evt |=> hold_ms == 11'(`WIPER_HOLD_MS - `WIPER_REPEAT_MS) ##1
      hold_ms >= 11'(`WIPER_HOLD_MS - `WIPER_REPEAT_MS))
    else $error("repeat interval not reloaded");
  a_idle_reverse: assert property (@(posedge core_clk) disable iff (!rst_n)
    idle_hit |=> rev_pending)
    else $error("idle time did not arm reversal");
  a_store_bit: assert property (@(posedge core_clk) disable iff (!rst_n)
    nv_write && $past(first_done, 2) |->
      nv_write_pos[`WIPER_STORE_BIT] != $past(stored_pos[`WIPER_STORE_BIT], 2))
    else $error("store without bit 3 change");
  a_store_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    store_due && !first_done |=> nv_write && nv_write_pos == $past(wiper_pos))
    else $error("first change not stored");
  a_single_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && single_style && src_press && rev_pending && !at_top && !at_bottom
      |=> (wiper_pos > $past(wiper_pos)) == !$past(dir_up))
    else $error("single style did not start opposite to last direction");
  a_rev_cleared: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && do_move && single_style && !idle_hit |=> !rev_pending)
    else $error("reversal still pending after a single style move");
  a_top_turn: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && single_style && src_press && at_top |=> wiper_pos == `WIPER_POS_MAX - 6'h01)
    else $error("single style did not turn at top end");
  a_step_any: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && step_c.press |=> $changed(wiper_pos))
    else $error("step input press did not move wiper");
  a_held_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    ready && held && !repeat_evt && !src_press |=> $stable(wiper_pos))
    else $error("wiper moved between repeat steps");
  a_restore_pos: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_now |=> ready && wiper_pos == $past(nv_restore_pos) &&
      single_mode == $past(strap3))
    else $error("restore or mode capture wrong");
  a_store_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    nv_write |-> $past(store_ms) == 11'(`WIPER_STORE_MS - 1))
    else $error("store before the full delay");

  // ------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------
  c_repeat: cover property (@(posedge core_clk) disable iff (!rst_n) repeat_evt);
  c_store: cover property (@(posedge core_clk) disable iff (!rst_n) nv_write);
  c_reverse: cover property (@(posedge core_clk) disable iff (!rst_n)
    do_move && single_style && hits_end);
  c_dual_block: cover property (@(posedge core_clk) disable iff (!rst_n)
    move_evt && blocked);
  c_idle_turn: cover property (@(posedge core_clk) disable iff (!rst_n)
    do_move && single_style && rev_pending && src_press);
endmodule

// *** hw/wiper_map.svh ***
`ifndef WIPER_MAP_SVH
`define WIPER_MAP_SVH

// ------------------------------------------------------------
// Wiper range
// ------------------------------------------------------------
`define WIPER_POS_W 6
`define WIPER_POS_MAX 6'h3F
`define WIPER_POS_MIN 6'h00
`define WIPER_STORE_BIT 3

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define WIPER_CLK_NS 40
`define WIPER_CONTACT_MIN_NS 1000000
`define WIPER_STEP_MIN_NS 1000
`define WIPER_TICK_NS 1000000
`define WIPER_CONTACT_MIN_CYCLES ((`WIPER_CONTACT_MIN_NS + `WIPER_CLK_NS - 1) / `WIPER_CLK_NS)
`define WIPER_STEP_MIN_CYCLES ((`WIPER_STEP_MIN_NS + `WIPER_CLK_NS - 1) / `WIPER_CLK_NS)
`define WIPER_TICK_CYCLES (`WIPER_TICK_NS / `WIPER_CLK_NS)
`define WIPER_HOLD_MS 1000
`define WIPER_REPEAT_MS 100
`define WIPER_IDLE_MS 1000
`define WIPER_STORE_MS 2000
`define WIPER_MS_W 11

`endif

// *** hw/wiper_pkg.sv ***
package wiper_pkg;
  typedef logic [5:0] pos_t;
  typedef logic [10:0] ms_t;
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_STEP,
    SRC_UP,
    SRC_DOWN
  } source_e;
endpackage

// *** hw/contact_if.sv ***
`timescale 1ns/1ns
interface contact_if;
  logic asserted;
  logic press;
  modport filt (output asserted, output press);
  modport user (input asserted, input press);
endinterface

// *** hw/ms_tick.sv ***
`timescale 1ns/1ns
module ms_tick #(
  parameter int CYCLES = 25000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt;
  wire wrap = (cnt == CW'(CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= wrap ? '0 : cnt + 1'b1;
      tick <= wrap;
    end
  end
endmodule

// *** hw/contact_filter.sv ***
`timescale 1ns/1ns
module contact_filter #(
  parameter int MIN_CYCLES = 25000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_n,
  contact_if.filt out
);
  localparam int CW = $clog2(MIN_CYCLES + 1);
  logic s1;
  logic s2;
  logic s3;
  logic level_high;
  logic [CW-1:0] cnt;

  // ------------------------------------------------------------
  // Sync and debounce
  // ------------------------------------------------------------
  // A level change must hold for MIN_CYCLES; shorter highs merge lows
  wire agree = (s2 == s3);
  wire differs = agree && (s3 != level_high);
  wire flip = differs && (cnt == CW'(MIN_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level_high <= 1'b1;
      cnt <= '0;
      out.press <= 1'b0;
    end else begin
      s1 <= pin_n;
      s2 <= s1;
      s3 <= s2;
      cnt <= (differs && !flip) ? cnt + 1'b1 : '0;
      if (flip) begin
        level_high <= s3;
      end
      out.press <= flip && !s3;
    end
  end

  assign out.asserted = !level_high;

  a_release_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(level_high) |-> $past(cnt) == CW'(MIN_CYCLES - 1) && $past(s3))
    else $error("release without full high gap");
  a_press_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(level_high) |-> $past(cnt) == CW'(MIN_CYCLES - 1) && !$past(s3))
    else $error("press without full low width");
endmodule

// *** dv/contact_driver.sv ***
`timescale 1ns/1ns
module contact_driver (
  input wire logic core_clk,
  output logic up_n,
  output logic down_n,
  output logic step_n
);
  // ----------------------------------------
  // Released pins
  // ----------------------------------------
  // Released pins sit at the pull-up level, so idle is high
  // Down contact stays released through power-up
  initial begin
    up_n = 1'b1;
    down_n = 1'b1;
    step_n = 1'b1;
  end

  // ----------------------------------------
  // Pulses
  // ----------------------------------------
  task automatic drive(input int sel, input logic lvl);
    if (sel == 0) begin
      up_n <= lvl;
    end else if (sel == 1) begin
      down_n <= lvl;
    end else begin
      step_n <= lvl;
    end
  endtask

  // Falling edge starts the pulse; caller sets low and high widths
  task automatic pulse(input int sel, input int low_cyc, input int high_cyc);
    @(posedge core_clk);
    drive(sel, 1'b0);
    repeat (low_cyc) @(posedge core_clk);
    drive(sel, 1'b1);
    repeat (high_cyc) @(posedge core_clk);
  endtask

  // Real contacts chatter at closing and mid-press, far shorter than a valid pulse
  task automatic bounce(input int sel, input int low_cyc);
    pulse(sel, 2, 1);
    pulse(sel, low_cyc, 2);
    pulse(sel, low_cyc, low_cyc);
  endtask
endmodule

// *** dv/pulse_driven_wiper_stepper_tb.sv ***
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("BAD %s expected %0h seen %0h", what, exp, got); \
  end \
end

module pulse_driven_wiper_stepper_tb;
  // Short tick keeps the run small: one ms is TICK cycles
  localparam int TICK = 8;
  localparam int MIN = 6;
  localparam int STEP_MIN = 25;
  localparam int CPW = 2 * TICK;
  localparam int SPW = STEP_MIN + 5;
  logic core_clk;
  logic rst_n;
  logic down_tied_supply;
  logic [5:0] nv_restore_pos;
  logic up_n;
  logic down_n;
  logic step_n;
  logic [5:0] wiper_pos;
  logic nv_write;
  logic [5:0] nv_write_pos;
  logic single_mode;
  logic ready;
  int mismatches;
  int checks_done;
  int writes;
  logic [5:0] last_stored;

  contact_driver u_drv (
    .core_clk(core_clk),
    .up_n(up_n),
    .down_n(down_n),
    .step_n(step_n)
  );

  wiper_stepper #(
    .TICK_CYCLES(TICK),
    .CONTACT_MIN_CYCLES(MIN),
    .STEP_MIN_CYCLES(STEP_MIN)
  ) u_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .up_contact_in_n(up_n),
    .down_contact_in_n(down_n),
    .step_in_n(step_n),
    .down_tied_supply(down_tied_supply),
    .nv_restore_pos(nv_restore_pos),
    .wiper_pos(wiper_pos),
    .nv_write(nv_write),
    .nv_write_pos(nv_write_pos),
    .single_mode(single_mode),
    .ready(ready)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (nv_write === 1'b1) begin
      writes <= writes + 1;
      last_stored <= nv_write_pos;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic start_up(input logic strap, input logic [5:0] pos);
    @(posedge core_clk);
    rst_n <= 1'b0;
    down_tied_supply <= strap;
    nv_restore_pos <= pos;
    repeat (6) @(posedge core_clk);
    `CHECK("reset wiper", 6'h00, wiper_pos)
    `CHECK("reset ready", 1'b0, ready)
    rst_n <= 1'b1;
    for (int i = 0; i < 4 * TICK && ready !== 1'b1; i++) @(posedge core_clk);
    `CHECK("ready", 1'b1, ready)
    @(posedge core_clk);
  endtask

  task automatic move(input int sel, input int w, input logic [5:0] exp, input string what);
    u_drv.pulse(sel, w, w);
    `CHECK(what, exp, wiper_pos)
  endtask

  task automatic wait_ms(input int ms);
    repeat (ms * TICK) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic restore_dual;
    start_up(1'b0, 6'h3E);
    `CHECK("restored", 6'h3E, wiper_pos)
    `CHECK("dual mode", 1'b0, single_mode)
  endtask

  // Step pulses of SPW cycles, nearly twice a contact pulse here, still count
  task automatic step_input;
    move(2, SPW, 6'h3F, "step up");
    move(2, SPW, 6'h3E, "step end reverse");
    move(2, SPW, 6'h3D, "fast step 1");
    move(2, SPW, 6'h3C, "fast step 2");
    move(2, SPW, 6'h3B, "fast step 3");
  endtask

  task automatic dual_buttons;
    move(0, CPW, 6'h3C, "dual up");
    move(1, CPW, 6'h3B, "dual down");
    for (int i = 1; i <= 4; i++) begin
      move(0, CPW, 6'h3B + 6'(i), "dual up run");
    end
    move(0, CPW, 6'h3F, "dual hold top");
    move(1, CPW, 6'h3E, "dual leave top");
  endtask

  task automatic contact_noise;
    move(0, 3, 6'h3E, "glitch");
    u_drv.bounce(1, CPW);
    `CHECK("chatter merge", 6'h3D, wiper_pos)
  endtask

  // Four steps: press, one second, then two 100 ms repeats before release
  task automatic hold_repeat;
    u_drv.pulse(1, 1250 * TICK, CPW);
    `CHECK("held down", 6'h39, wiper_pos)
  endtask

  task automatic storage;
    wait_ms(2100);
    `CHECK("first store count", 1, writes)
    `CHECK("first store pos", 6'h39, last_stored)
    move(1, CPW, 6'h38, "to 56");
    wait_ms(2100);
    `CHECK("bit3 same", 1, writes)
    move(1, CPW, 6'h37, "to 55");
    wait_ms(2100);
    `CHECK("bit3 change", 2, writes)
    `CHECK("bit3 pos", 6'h37, last_stored)
  endtask

  task automatic single_button;
    start_up(1'b1, 6'h01);
    `CHECK("single mode", 1'b1, single_mode)
    move(0, CPW, 6'h02, "single up");
    move(0, CPW, 6'h03, "single up again");
    move(1, CPW, 6'h03, "down ignored");
    wait_ms(1100);
    move(0, CPW, 6'h02, "idle reverse");
    move(0, CPW, 6'h01, "single down");
    move(0, CPW, 6'h00, "reach bottom");
    move(0, CPW, 6'h01, "bottom reverse");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    down_tied_supply = 1'b0;
    nv_restore_pos = 6'h3E;
    mismatches = 0;
    checks_done = 0;
    writes = 0;
    last_stored = 6'h00;
    restore_dual();
    step_input();
    dual_buttons();
    contact_noise();
    hold_repeat();
    storage();
    single_button();
    complete_run();
  end

  // Tests need about 70k cycles (2.8 ms); the 3.6 ms limit allows over a quarter more
  initial begin
    #3600000;
    mismatches++;
    complete_run();
  end
endmodule
